/* File: core/rscs_cfg.svh */
`ifndef RSCS_CFG_SVH
`define RSCS_CFG_SVH

// Register bus geometry.
`define RSCS_ADDR_W 4
`define RSCS_DATA_W 16

// Register offsets, one word each.
`define RSCS_OFS_STRAP 4'h0
`define RSCS_OFS_DIR 4'h1
`define RSCS_OFS_OUT 4'h2
`define RSCS_OFS_IN 4'h3
`define RSCS_OFS_IRQ_EN 4'h4
`define RSCS_OFS_EDGE_POL 4'h5
`define RSCS_OFS_STATUS 4'h6
`define RSCS_OFS_MASK 4'h7
`define RSCS_OFS_CARD 4'h8

// Field positions.
`define RSCS_STRAP_DRV_BIT 0
`define RSCS_STRAP_FREQ_LSB 1
`define RSCS_STRAP_FREQ_MSB 2
`define RSCS_STRAP_RSV_BIT 3
`define RSCS_STRAP_DONE_BIT 4
`define RSCS_CARD_SEL_BIT 0
`define RSCS_CARD_ON_BIT 1
`define RSCS_SHARED_PIN 11

// Reset values.
`define RSCS_RST_WORD 16'h0000
`define RSCS_RST_FREQ 2'h0

// Pins that have no edge interrupt (bits 15 down to 12).
`define RSCS_EDGE_MASK 16'h0fff

// Least width of the chip reset pulse, and its cycles at 10 MHz.
`define RSCS_CLK_HZ 10000000
`define RSCS_RESET_MIN_NS 1000
`define RSCS_RESET_MIN_CYC ((`RSCS_RESET_MIN_NS * (`RSCS_CLK_HZ / 1000000) + 999) / 1000)

`endif

/* File: core/rscs_pin.sv */
`timescale 1ns/1ps
`include "rscs_cfg.svh"

module rscs_pin import rscs_pkg::*; #(
   parameter bit EDGE_CAPABLE = 1'b1
) (
   input wire logic i_clock,    // System clock.
   input wire logic i_arst_n,   // Asynchronous reset, active low.
   input wire logic i_pin,      // Raw pin level.
   input wire logic i_irq_en,   // Edge interrupt enable.
   input wire logic i_rise_sel, // One picks rising edges, zero falling.
   output logic o_level,        // Filtered pin level.
   output logic o_edge          // One-cycle pulse on a selected edge.
);

   logic s1_r, s2_r, s3_r, lvl_r, edge_r;
   logic s1_nxt, s2_nxt, s3_nxt, lvl_nxt, edge_nxt;

   // A level only counts once the second and third stages agree, so a
   // metastable first stage never reaches the filter.
   always_comb begin
      s1_nxt = i_pin;
      s2_nxt = s1_r;
      s3_nxt = s2_r;
      lvl_nxt = (s2_r == s3_r) ? s3_r : lvl_r;
      edge_nxt = 1'b0;
      if (EDGE_CAPABLE && i_irq_en && (lvl_nxt != lvl_r)) begin // see R10
         edge_nxt = (lvl_nxt == i_rise_sel);
      end
   end

   // Registers of the synchroniser and edge detector.
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         lvl_r <= 1'b0;
         edge_r <= 1'b0;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         s3_r <= s3_nxt;
         lvl_r <= lvl_nxt;
         edge_r <= edge_nxt;
      end
   end

   assign o_level = lvl_r;
   assign o_edge = edge_r;

endmodule

/* File: core/rscs_pkg.sv */
package rscs_pkg;

   // Strap capture progress.
   typedef enum logic [0:0] {
      RSCS_ST_SAMPLE = 1'b0,
      RSCS_ST_LATCHED = 1'b1
   } rscs_state_t;

   // Clock source picked by the drive strap.
   typedef enum logic [0:0] {
      RSCS_SRC_CRYSTAL = 1'b0,
      RSCS_SRC_EXTERNAL = 1'b1
   } rscs_src_t;

   // Input frequency codes; only the first is legal.
   typedef enum logic [1:0] {
      RSCS_FREQ_24MHZ = 2'b00,
      RSCS_FREQ_RSV1 = 2'b01,
      RSCS_FREQ_RSV2 = 2'b10,
      RSCS_FREQ_RSV3 = 2'b11
   } rscs_freq_t;

endpackage

/* File: core/rscs_top.sv */
// How it works
// R1 - The drive and frequency straps are sampled all through reset and held at the first edge after release.
// R2 - A held drive strap of zero selects the 24MHz crystal and one selects an external 24MHz clock.
// R3 - Frequency code 00 means a 24MHz input and the other codes are reserved and must not be strapped.
// R4 - The drive strap pull-down is on during reset and off once the strap is held.
// R5 - Both frequency strap pull-downs are on during reset and off once the code is held.
// R6 - The board holds the chip reset low for at least one microsecond.
// R7 - Pin eleven works as input, edge interrupt input or output, or carries the third card supply switch.
// R8 - Pins fifteen to twelve are input or output only and never raise an edge interrupt.
// R9 - The memory chip enable stays asserted low except while the controller is in standby.
// R10 - Each edge-capable pin is a plain input, an edge interrupt input or an output by configuration.
// R11 - The held strap values stay fixed until the next reset whatever the pins do later.
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "rscs_cfg.svh"

module rscs_top import rscs_pkg::*; #(
   parameter int NUM_PINS = 16,
   parameter logic [15:0] EDGE_MASK = `RSCS_EDGE_MASK
) (
   input wire logic i_clock,                      // 10 MHz system clock.
   input wire logic i_arst_n,                     // Chip reset, active low.
   input wire logic [`RSCS_ADDR_W-1:0] i_addr,    // Register address.
   input wire logic [`RSCS_DATA_W-1:0] i_wdata,   // Register write data.
   input wire logic i_wr,                         // Write strobe.
   input wire logic i_rd,                         // Read strobe.
   output logic [`RSCS_DATA_W-1:0] o_rdata,       // Read data, cycle after strobe.
   output logic o_irq,                            // Level interrupt.
   input wire logic i_clock_drive_strap,          // Drive strap pin level.
   input wire logic [1:0] i_clock_freq_strap,     // Frequency strap pin levels.
   output logic o_clock_drive_strap_pd_en,        // Drive strap pull-down enable.
   output logic [1:0] o_clock_freq_strap_pd_en,   // Frequency strap pull-down enables.
   output logic o_clock_src_external,             // One selects external clock.
   output logic [1:0] o_clock_freq_code,          // Held frequency code.
   output logic o_clock_freq_reserved,            // Held code is a reserved one.
   output logic o_strap_latched,                  // Straps have been held.
   input wire logic [NUM_PINS-1:0] i_gpio,        // General pin levels in.
   output logic [NUM_PINS-1:0] o_gpio,            // General pin levels out.
   output logic [NUM_PINS-1:0] o_gpio_oe,         // General pin output enables.
   input wire logic i_mcu_standby,                // Controller standby, same clock.
   output logic o_memory_chip_enable_low          // Memory chip enable, active low.
);

   // The register map is 16 bits wide; refuse layouts it cannot hold.
   if (NUM_PINS != 16) begin : g_bad_pins
      $error("rscs_top supports exactly 16 general pins");
   end
   if (EDGE_MASK[15:12] != 4'h0) begin : g_bad_mask
      $error("rscs_top pins 15 to 12 cannot be edge capable");
   end

   // ------------------------------------------------------------------
   // Strap capture.
   // ------------------------------------------------------------------
   logic [2:0] st1_r, st2_r, st3_r, stf_r;
   logic [2:0] stf_nxt;
   rscs_state_t state_r, state_nxt;
   rscs_src_t src_r, src_nxt;
   rscs_freq_t freq_r, freq_nxt;

   // The strap pins are synchronised without reset so that they keep
   // sampling while the chip reset is held; reset cannot load a pin value.
   always_comb begin
      stf_nxt = stf_r;
      if (st2_r == st3_r) begin
         stf_nxt = st3_r;
      end
   end

   // Strap synchroniser and filter registers.
   always_ff @(posedge i_clock) begin
      st1_r <= {i_clock_freq_strap, i_clock_drive_strap}; // see R1
      st2_r <= st1_r;
      st3_r <= st2_r;
      stf_r <= stf_nxt;
   end

   // The first edge after release takes the filtered strap value; the
   // latched state then ignores the pins until the next reset.
   always_comb begin
      state_nxt = state_r;
      src_nxt = src_r;
      freq_nxt = freq_r;
      case (state_r)
         RSCS_ST_SAMPLE: begin
            src_nxt = rscs_src_t'(stf_r[0]); // see R1, R2
            freq_nxt = rscs_freq_t'(stf_r[2:1]); // see R1, R3
            state_nxt = RSCS_ST_LATCHED;
         end
         RSCS_ST_LATCHED: begin
            state_nxt = RSCS_ST_LATCHED; // see R11
         end
         default: begin
            state_nxt = RSCS_ST_SAMPLE;
         end
      endcase
   end

   // Held strap registers; reset loads crystal and 24MHz.
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_r <= RSCS_ST_SAMPLE;
         src_r <= RSCS_SRC_CRYSTAL;
         freq_r <= RSCS_FREQ_24MHZ;
      end else begin
         state_r <= state_nxt;
         src_r <= src_nxt;
         freq_r <= freq_nxt;
      end
   end

   // Pull-downs follow the capture state, so they stay on through reset
   // and drop only once the value is held.
   assign o_clock_drive_strap_pd_en = (state_r == RSCS_ST_SAMPLE); // see R4
   assign o_clock_freq_strap_pd_en = {2{state_r == RSCS_ST_SAMPLE}}; // see R5
   assign o_clock_src_external = (src_r == RSCS_SRC_EXTERNAL); // see R2
   assign o_clock_freq_code = freq_r;
   assign o_clock_freq_reserved = (freq_r != RSCS_FREQ_24MHZ); // see R3
   assign o_strap_latched = (state_r == RSCS_ST_LATCHED);

   // ------------------------------------------------------------------
   // General pins.
   // ------------------------------------------------------------------
   logic [NUM_PINS-1:0] pin_level;
   logic [NUM_PINS-1:0] pin_edge;
   logic [15:0] dir_r, out_r, irq_en_r, pol_r, status_r, mask_r;
   logic [15:0] dir_nxt, out_nxt, irq_en_nxt, pol_nxt, status_nxt, mask_nxt;
   logic card_sel_r, card_on_r, card_sel_nxt, card_on_nxt;

   // One filter and edge detector per pin; the upper four are built
   // without the edge path at all.
   for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
      rscs_pin #(
         .EDGE_CAPABLE(EDGE_MASK[g]) // see R8, R10
      ) u_pin (
         .i_clock(i_clock),
         .i_arst_n(i_arst_n),
         .i_pin(i_gpio[g]),
         .i_irq_en(irq_en_r[g]),
         .i_rise_sel(pol_r[g]),
         .o_level(pin_level[g]),
         .o_edge(pin_edge[g])
      );
   end

   // ------------------------------------------------------------------
   // Register writes and sticky status.
   // ------------------------------------------------------------------
   logic wr_hit;
   assign wr_hit = i_wr;

   // Writes update control registers; a status bit set by an edge in the
   // same cycle as its clear stays set, so no event is lost.
   always_comb begin
      dir_nxt = dir_r;
      out_nxt = out_r;
      irq_en_nxt = irq_en_r;
      pol_nxt = pol_r;
      mask_nxt = mask_r;
      card_sel_nxt = card_sel_r;
      card_on_nxt = card_on_r;
      status_nxt = status_r;
      if (wr_hit) begin
         case (i_addr)
            `RSCS_OFS_DIR: begin
               dir_nxt = i_wdata; // see R7, R10
            end
            `RSCS_OFS_OUT: begin
               out_nxt = i_wdata;
            end
            `RSCS_OFS_IRQ_EN: begin
               irq_en_nxt = i_wdata & EDGE_MASK; // see R8
            end
            `RSCS_OFS_EDGE_POL: begin
               pol_nxt = i_wdata;
            end
            `RSCS_OFS_STATUS: begin
               status_nxt = status_r & ~i_wdata;
            end
            `RSCS_OFS_MASK: begin
               mask_nxt = i_wdata;
            end
            `RSCS_OFS_CARD: begin
               card_sel_nxt = i_wdata[`RSCS_CARD_SEL_BIT]; // see R7
               card_on_nxt = i_wdata[`RSCS_CARD_ON_BIT];
            end
            default: begin
               status_nxt = status_r;
            end
         endcase
      end
      status_nxt = status_nxt | (pin_edge & EDGE_MASK); // see R8, R10
   end

   // Control and status registers.
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         dir_r <= `RSCS_RST_WORD;
         out_r <= `RSCS_RST_WORD;
         irq_en_r <= `RSCS_RST_WORD;
         pol_r <= `RSCS_RST_WORD;
         status_r <= `RSCS_RST_WORD;
         mask_r <= `RSCS_RST_WORD;
         card_sel_r <= 1'b0;
         card_on_r <= 1'b0;
      end else begin
         dir_r <= dir_nxt;
         out_r <= out_nxt;
         irq_en_r <= irq_en_nxt;
         pol_r <= pol_nxt;
         status_r <= status_nxt;
         mask_r <= mask_nxt;
         card_sel_r <= card_sel_nxt;
         card_on_r <= card_on_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Pin drive, interrupt and memory enable outputs.
   // ------------------------------------------------------------------
   logic [15:0] gpio_o_r, gpio_oe_r, gpio_o_nxt, gpio_oe_nxt;
   logic irq_r, irq_nxt, mce_low_r, mce_low_nxt;

   // Drive values are registered so the pads never see a decode glitch;
   // the card supply takes over pin eleven whatever its direction bit.
   always_comb begin
      gpio_o_nxt = out_r;
      gpio_oe_nxt = dir_r; // see R7, R8, R10
      if (card_sel_r) begin
         gpio_o_nxt[`RSCS_SHARED_PIN] = card_on_r; // see R7
         gpio_oe_nxt[`RSCS_SHARED_PIN] = 1'b1;
      end
      irq_nxt = |(status_nxt & mask_nxt);
      mce_low_nxt = i_mcu_standby; // see R9
   end

   // Output registers; the memory enable comes out of reset asserted.
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         gpio_o_r <= `RSCS_RST_WORD;
         gpio_oe_r <= `RSCS_RST_WORD;
         irq_r <= 1'b0;
         mce_low_r <= 1'b0; // see R9
      end else begin
         gpio_o_r <= gpio_o_nxt;
         gpio_oe_r <= gpio_oe_nxt;
         irq_r <= irq_nxt;
         mce_low_r <= mce_low_nxt;
      end
   end

   assign o_gpio = gpio_o_r;
   assign o_gpio_oe = gpio_oe_r;
   assign o_irq = irq_r;
   assign o_memory_chip_enable_low = mce_low_r;

   // ------------------------------------------------------------------
   // Register reads.
   // ------------------------------------------------------------------
   logic [15:0] rdata_r, rdata_nxt;
   logic [15:0] strap_word;

   // Strap readback: held drive, held code, reserved flag and done flag.
   always_comb begin
      strap_word = `RSCS_RST_WORD;
      strap_word[`RSCS_STRAP_DRV_BIT] = o_clock_src_external;
      strap_word[`RSCS_STRAP_FREQ_MSB:`RSCS_STRAP_FREQ_LSB] = freq_r;
      strap_word[`RSCS_STRAP_RSV_BIT] = o_clock_freq_reserved;
      strap_word[`RSCS_STRAP_DONE_BIT] = o_strap_latched;
   end

   // Read data stand for exactly the cycle after the strobe and are zero
   // otherwise, also for unmapped addresses.
   always_comb begin
      rdata_nxt = `RSCS_RST_WORD;
      if (i_rd) begin
         case (i_addr)
            `RSCS_OFS_STRAP: begin
               rdata_nxt = strap_word;
            end
            `RSCS_OFS_DIR: begin
               rdata_nxt = dir_r;
            end
            `RSCS_OFS_OUT: begin
               rdata_nxt = out_r;
            end
            `RSCS_OFS_IN: begin
               rdata_nxt = pin_level;
            end
            `RSCS_OFS_IRQ_EN: begin
               rdata_nxt = irq_en_r;
            end
            `RSCS_OFS_EDGE_POL: begin
               rdata_nxt = pol_r;
            end
            `RSCS_OFS_STATUS: begin
               rdata_nxt = status_r;
            end
            `RSCS_OFS_MASK: begin
               rdata_nxt = mask_r;
            end
            `RSCS_OFS_CARD: begin
               rdata_nxt = {14'h0000, card_on_r, card_sel_r};
            end
            default: begin
               rdata_nxt = `RSCS_RST_WORD;
            end
         endcase
      end
   end

   // Read data register.
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rdata_r <= `RSCS_RST_WORD;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign o_rdata = rdata_r;

endmodule

/* File: test/reset_strap_clock_select_test.sv */
`timescale 1ns/1ps
`include "rscs_cfg.svh"

module reset_strap_clock_select_test;
   logic i_clock = 1'b0;
   logic [3:0] i_addr = 4'h0;
   logic [15:0] i_wdata = 16'h0000, i_gpio = 16'h0000, rdat, prev, nw, exp, o_rdata, o_gpio, o_gpio_oe;
   logic i_wr = 1'b0, i_rd = 1'b0, i_mcu_standby = 1'b0, req = 1'b1, fit = 1'b1;
   logic o_irq, o_clock_src_external, o_clock_freq_reserved, o_strap_latched, o_memory_chip_enable_low;
   logic [1:0] o_clock_freq_code;
   logic [2:0] val = 3'h0;
   logic [31:0] seed = 32'h0ffcdcaf;
   wire [2:0] pin, pd;
   wire i_arst_n;
   int num_errors = 0, num_checks = 0;

   rscs_top uut (.i_clock, .i_arst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_irq,
      .i_clock_drive_strap(pin[0]), .i_clock_freq_strap(pin[2:1]), .o_clock_drive_strap_pd_en(pd[0]),
      .o_clock_freq_strap_pd_en(pd[2:1]), .o_clock_src_external, .o_clock_freq_code, .o_clock_freq_reserved,
      .o_strap_latched, .i_gpio, .o_gpio, .o_gpio_oe, .i_mcu_standby, .o_memory_chip_enable_low);
   rscs_board board (.i_clock, .i_req(req), .i_fit(fit), .i_val(val), .i_pd_en(pd), .o_arst_n(i_arst_n),
      .o_pin(pin));

   // Free-running 10 MHz clock.
   always #50 i_clock = ~i_clock;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] want);
      num_checks++;
      if (got !== want) begin
         num_errors++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, want);
      end
   endtask

   // Bus tasks release their strobe at the edge that takes it.
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_clock);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clock);
      i_wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a);
      @(posedge i_clock);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1 rdat = o_rdata;
   endtask

   // Expected strap word: held, reserved flag, code, source.
   task automatic reboot(input logic [2:0] v, input logic f);
      logic [15:0] e;
      @(posedge i_clock);
      val <= v;
      fit <= f;
      req <= 1'b1;
      repeat (16) @(posedge i_clock);
      #1 chk(16'(pd), 16'h0007);
      e = {11'h0, 1'b1, v[2:1] != 2'h0, v} & (f ? 16'hffff : 16'h0010);
      @(posedge i_clock);
      req <= 1'b0;
      // The board keeps reset low ten more edges, so wait for release and hold.
      repeat (12) @(posedge i_clock);
      val <= ~v;
      #1 chk({11'h0, o_strap_latched, o_clock_freq_reserved, o_clock_freq_code, o_clock_src_external}, e);
      chk(16'(pd), 16'h0000);
      repeat (8) @(posedge i_clock);
      rd(`RSCS_OFS_STRAP);
      chk(rdat, e);
   endtask

   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Cuts a hang short well past the five hundred or so cycles the run needs.
   initial begin
      repeat (20000) @(posedge i_clock);
      num_errors++;
      give_verdict();
   end

   initial begin
      // Every strap code, reserved ones included, then unfitted pins.
      for (int k = 0; k < 8; k++) begin
         reboot(k[2:0], 1'b1);
      end
      reboot(3'h5, 1'b0);
      wr(`RSCS_OFS_STRAP, 16'hffff);
      rd(`RSCS_OFS_STRAP);
      chk(rdat, 16'h0010);
      rd(4'hf);
      chk(rdat, 16'h0000);
      $display("strap tests done");
      // Direction, output and input words on random patterns.
      for (int k = 0; k < 4; k++) begin
         seed = lfsr(seed);
         @(posedge i_clock);
         i_gpio <= seed[15:0];
         wr(`RSCS_OFS_DIR, seed[15:0]);
         wr(`RSCS_OFS_OUT, seed[31:16]);
         repeat (6) @(posedge i_clock);
         #1 chk(o_gpio_oe, seed[15:0]);
         chk(o_gpio & seed[15:0], seed[31:16] & seed[15:0]);
         rd(`RSCS_OFS_IN);
         chk(rdat, seed[15:0]);
      end
      // Edge events in both polarities, masking and write-one clearing.
      wr(`RSCS_OFS_IRQ_EN, 16'hffff);
      rd(`RSCS_OFS_IRQ_EN);
      chk(rdat, `RSCS_EDGE_MASK);
      for (int p = 0; p < 2; p++) begin
         seed = lfsr(seed);
         prev = {seed[31:28], ~p[0], seed[26:16]};
         nw = {seed[15:12], p[0], seed[10:0]};
         @(posedge i_clock);
         i_gpio <= prev;
         repeat (8) @(posedge i_clock);
         wr(`RSCS_OFS_MASK, 16'hffff);
         wr(`RSCS_OFS_STATUS, 16'hffff);
         wr(`RSCS_OFS_EDGE_POL, {16{p[0]}});
         exp = (p[0] ? nw & ~prev : ~nw & prev) & `RSCS_EDGE_MASK;
         @(posedge i_clock);
         i_gpio <= nw;
         repeat (8) @(posedge i_clock);
         rd(`RSCS_OFS_STATUS);
         chk(rdat, exp);
         chk(16'(o_irq), 16'h0001);
         wr(`RSCS_OFS_MASK, 16'h0000);
         #1 chk(16'(o_irq), 16'h0000);
         wr(`RSCS_OFS_MASK, 16'hffff);
         wr(`RSCS_OFS_STATUS, exp);
         rd(`RSCS_OFS_STATUS);
         chk(rdat | 16'(o_irq), 16'h0000);
      end
      // The card supply takes pin eleven, with the direction word left as the last random pattern wrote it.
      for (int c = 3; c > 0; c -= 2) begin
         wr(`RSCS_OFS_CARD, 16'(c));
         repeat (3) @(posedge i_clock);
         #1 chk({14'h0, o_gpio_oe[11], o_gpio[11]}, {14'h0, 1'b1, c[1]});
      end
      wr(`RSCS_OFS_CARD, 16'h0000);
      $display("pin tests done");
      // Memory enable leaves its asserted level only in standby.
      for (int s = 1; s >= 0; s--) begin
         @(posedge i_clock);
         i_mcu_standby <= s[0];
         repeat (2) @(posedge i_clock);
         #1 chk(16'(o_memory_chip_enable_low), 16'(s));
      end
      $display("standby tests done");
      give_verdict();
   end
endmodule

/* File: test/rscs_board.sv */
`timescale 1ns/1ps

// Board side: the reset source and the strap resistors.
module rscs_board #(
   parameter int RST_CYC = 10
) (
   input wire logic i_clock, // System clock.
   input wire logic i_req, // Bench asks for a chip reset.
   input wire logic i_fit, // Straps fitted, else the pins float.
   input wire logic [2:0] i_val, // Strapped levels, frequency over drive.
   input wire logic [2:0] i_pd_en, // Chip pull-down enables.
   output logic o_arst_n, // Chip reset, active low.
   output logic [2:0] o_pin // Strap pin levels.
);
   int cnt = 0;
   logic [2:0] last = 3'h0;

   // Ten cycles at 10 MHz keep even a short request a full microsecond wide.
   always @(posedge i_clock) begin
      cnt <= i_req ? RST_CYC : (cnt > 0 ? cnt - 1 : 0);
      last <= o_pin;
   end
   assign o_arst_n = !i_req && cnt == 0;

   // A floating pin rests on the pull-down, and wanders once that is off.
   always_comb begin
      for (int k = 0; k < 3; k++) begin
         o_pin[k] = i_fit ? i_val[k] : (i_pd_en[k] ? 1'b0 : ~last[k]);
      end
   end
endmodule

/* File: test/rscs_top_asserts.sv */
`timescale 1ns/1ps
`include "rscs_cfg.svh"

// Watches strap capture, pin drive and the memory enable at the top ports.
module rscs_top_asserts #(
   parameter int NUM_PINS = 16
) (
   input wire logic i_clock, // System clock.
   input wire logic i_arst_n, // Chip reset, active low.
   input wire logic [`RSCS_ADDR_W-1:0] i_addr, // Register address.
   input wire logic [`RSCS_DATA_W-1:0] i_wdata, // Write data.
   input wire logic i_wr, // Write strobe.
   input wire logic i_clock_drive_strap, // Drive strap pin.
   input wire logic o_clock_drive_strap_pd_en, // Drive pull-down.
   input wire logic [1:0] o_clock_freq_strap_pd_en, // Frequency pull-downs.
   input wire logic o_clock_src_external, // Held source.
   input wire logic [1:0] o_clock_freq_code, // Held code.
   input wire logic o_clock_freq_reserved, // Reserved code flag.
   input wire logic o_strap_latched, // Straps held.
   input wire logic [NUM_PINS-1:0] o_gpio_oe, // Pin output enables.
   input wire logic i_mcu_standby, // Controller standby.
   input wire logic o_memory_chip_enable_low // Memory enable, active low.
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_arst_n);

   // A direction write lands on the enables after two register stages.
   sequence s_dir_wr;
      i_wr && i_addr == `RSCS_OFS_DIR;
   endsequence
   sequence s_oe_lands;
      ##2 o_gpio_oe[10:0] == $past(i_wdata[10:0], 2) && o_gpio_oe[15:12] == $past(i_wdata[15:12], 2);
   endsequence

   // Properties; pin eleven is left out as the card supply may own it.
   property p_latch; !o_strap_latched [*2] |=> o_strap_latched; endproperty
   property p_hold;
      o_strap_latched |=> o_strap_latched && $stable(o_clock_src_external) && $stable(o_clock_freq_code);
   endproperty
   property p_src; $rose(o_strap_latched) |-> o_clock_src_external == $past(i_clock_drive_strap, 5); endproperty
   property p_rsv; o_clock_freq_reserved == (o_clock_freq_code != 2'h0); endproperty
   property p_drv_pd; o_clock_drive_strap_pd_en != o_strap_latched; endproperty
   property p_freq_pd; o_clock_freq_strap_pd_en == {2{~o_strap_latched}}; endproperty
   property p_mce; o_memory_chip_enable_low == $past(i_mcu_standby); endproperty
   property p_dir_oe; s_dir_wr |-> s_oe_lands; endproperty

   a_latch: assert property (p_latch) else $error("straps not held after release");
   a_hold: assert property (p_hold) else $error("held strap value moved");
   a_src: assert property (p_src) else $error("clock source differs from strap");
   a_rsv: assert property (p_rsv) else $error("reserved flag wrong");
   a_drv_pd: assert property (p_drv_pd) else $error("drive pull-down wrong");
   a_freq_pd: assert property (p_freq_pd) else $error("frequency pull-down wrong");
   a_mce: assert property (p_mce) else $error("memory enable wrong");
   a_dir_oe: assert property (p_dir_oe) else $error("output enable wrong");
endmodule

bind rscs_top rscs_top_asserts #(.NUM_PINS(NUM_PINS)) u_chk (.i_clock, .i_arst_n, .i_addr, .i_wdata, .i_wr,
   .i_clock_drive_strap, .o_clock_drive_strap_pd_en, .o_clock_freq_strap_pd_en, .o_clock_src_external,
   .o_clock_freq_code, .o_clock_freq_reserved, .o_strap_latched, .o_gpio_oe, .i_mcu_standby,
   .o_memory_chip_enable_low);
